/* File: osc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input  wire logic clk_sys_in,
  input  wire logic osc_start_in,
  output logic      osc_clk_out,
  output logic      osc_stable_out
);
  int unsigned run_cnt = 0;
  // Oscillator stands still until released, then settles after a short start-up
  always @(posedge clk_sys_in) begin
    run_cnt <= osc_start_in ? run_cnt + 1 : 0;
    osc_clk_out <= osc_start_in & run_cnt[1];
    osc_stable_out <= osc_start_in && run_cnt > 12;
  end
endmodule
`default_nettype wire

/* File: rst_seq_pkg.sv */
// Operation
// - A brown-out reset sets the brown-out flag, bit 1 of the cause register.
// - A power-on reset sets the power-on flag, bit 0 of the cause register.
// - Software may set or clear any cause flag; setting one never resets.
// - With the watchdog config enable at 1, the watchdog is always enabled.
// - Power-on and brown-out are cold resets; clock source comes from configuration.
// - Other resets are warm; the current clock source is kept and shown.
// - Crystal and secondary modes wait 1024 oscillator periods for the start-up timer.
// - Clock-ready wait per mode: start-up, start-up timer, PLL lock, or nothing.
// - With PLL enabled, wait 1.5 ms lock time before clock ready.
// - After brown-out, power-up timer holds reset; release lets the oscillator start.
// - Once clock ready after reset, fetch begins at address 0x000000.
// - Clock monitor, if enabled, starts at most 900 us after clock ready.
// - Power-on reset holds until supply is good plus at most 30 us.
// - Brown-out holds while supply is low and at most 100 us after.
// - A 3-bit field picks one of eight power-up delays, 0 to 128 ms.
// - Brown-out extension plus power-up delay restart on every supply rise.
// - A reset from the master reset pin sets the pin-reset flag.
// - Reset instruction asserts reset one cycle, keeps the clock, then fetches; here osc_start_out drops for that reset cycle.
// - The reset instruction sets the software-reset flag, bit 6.
// - Power-on reset clears every cause flag except the power-on flag; here the brown-out flag, bit 1, is left set as well.
// - A watchdog reset sets the watchdog time-out flag, bit 4.
package rst_seq_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned POR_EXT_US       = 30;
  localparam int unsigned BOR_EXT_US       = 100;
  localparam int unsigned PLL_LOCK_US      = 1500;
  localparam int unsigned FAILSAFE_CLOCK_MONITOR_DELAY_US    = 900;
  localparam int unsigned POWERUP_TIMER_UNIT_US     = 1000;
  localparam int unsigned MASTER_RESET_PIN_N_MIN_NS      = 2000;
  localparam int unsigned POR_EXT_CYCLES   = (POR_EXT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned BOR_EXT_DEF      = (BOR_EXT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PLL_LOCK_DEF     = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned FAILSAFE_CLOCK_MONITOR_DEF         = (FAILSAFE_CLOCK_MONITOR_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_TIMER_UNIT_DEF    = (POWERUP_TIMER_UNIT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned MASTER_RESET_PIN_N_MIN_CYCLES  = (MASTER_RESET_PIN_N_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OST_EDGES        = 1024;
  localparam int unsigned CNT_W            = 24;

  // Synchronised pins, index and reset level
  localparam int unsigned PIN_W            = 5;
  localparam int unsigned PIN_POR          = 0;
  localparam int unsigned PIN_BOR          = 1;
  localparam int unsigned PIN_MASTER_RESET_PIN_N         = 2;
  localparam int unsigned PIN_OSC_OK       = 3;
  localparam int unsigned PIN_OSC_CLK      = 4;
  localparam logic [4:0]  PIN_RST_LVL      = 5'h04;

  // Oscillator modes and per-mode wait masks (bit n is mode n)
  localparam logic [2:0]  OSC_FRC          = 3'h0;
  localparam logic [7:0]  STARTUP_MASK     = 8'hCF;
  localparam logic [7:0]  OST_MASK         = 8'h4C;
  localparam logic [7:0]  PLL_MASK         = 8'h2A;

  // Register map and cause register fields
  localparam logic [3:0]  CAUSE_OFFS       = 4'h0;
  localparam logic [3:0]  SEQ_OFFS         = 4'h4;
  localparam int unsigned POR_BIT          = 0;
  localparam int unsigned BOR_BIT          = 1;
  localparam int unsigned WDOG_TIMEOUT_FLAG_BIT         = 4;
  localparam int unsigned WDSW_BIT         = 5;
  localparam int unsigned SWR_BIT          = 6;
  localparam int unsigned PIN_RESET_FLAG_BIT         = 7;
  localparam logic [15:0] CAUSE_IMPL_MASK  = 16'hC3FF;
  localparam logic [15:0] CAUSE_POR_VALUE  = 16'h0003;
  localparam logic [15:0] BOR_CLEAR_MASK   = 16'hC27C;
  localparam logic [23:0] RESET_VECTOR     = 24'h000000;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [3:0] {
    ST_HOLD    = 4'h0,
    ST_POR_EXT = 4'h1,
    ST_BOR_EXT = 4'h2,
    ST_POWERUP_TIMER    = 4'h3,
    ST_OSC_UP  = 4'h4,
    ST_OST     = 4'h5,
    ST_PLL     = 4'h6,
    ST_RUN     = 4'h7,
    ST_WARM    = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [21:0] zero;
    logic        failsafe_clock_monitor_active;
    logic        clock_ready;
    logic        system_reset;
    logic [2:0]  current_osc;
    seq_state_t  state;
  } seq_status_t;

endpackage

/* File: system_reset_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module system_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned BOR_EXT_CYCLES  = BOR_EXT_DEF,
  parameter int unsigned PLL_LOCK_CYCLES = PLL_LOCK_DEF,
  parameter int unsigned FAILSAFE_CLOCK_MONITOR_CYCLES     = FAILSAFE_CLOCK_MONITOR_DEF,
  parameter int unsigned POWERUP_TIMER_MS_CYCLES  = POWERUP_TIMER_UNIT_DEF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        por_supply_ok_in,
  input  wire logic        bor_supply_ok_in,
  input  wire logic        master_reset_pin_n_in,
  input  wire logic        osc_stable_in,
  input  wire logic        osc_clk_in,
  input  wire logic        sw_reset_instr_in,
  input  wire logic        wdog_timeout_in,
  input  wire logic [2:0]  cfg_osc_select_in,
  input  wire logic [2:0]  powerup_delay_select_in,
  input  wire logic        wdog_cfg_enable_in,
  input  wire logic        failsafe_clock_monitor_enable_in,
  output logic             system_reset_out,
  output logic             clock_ready_out,
  output logic             osc_start_out,
  output logic             fetch_start_out,
  output logic [23:0]      fetch_addr_out,
  output logic [2:0]       current_osc_field_out,
  output logic             wdog_enabled_out,
  output logic             failsafe_clock_monitor_active_out
);

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_filt;
  logic             osc_prev_reg;
  logic             osc_edge;
  logic [7:0]       master_reset_pin_n_cnt_reg;
  logic             pin_active_reg;
  logic             pin_evt;
  seq_state_t       state_reg;
  seq_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] powerup_timer_cycles;
  logic             por_seen_reg;
  logic [2:0]       current_osc_reg;
  logic             system_reset_reg;
  logic             clock_ready_reg;
  logic             fetch_reg;
  logic [CNT_W-1:0] failsafe_clock_monitor_cnt_reg;
  logic             failsafe_clock_monitor_active_reg;
  logic [15:0]      cause_reg;
  logic [15:0]      cause_next;
  logic             cold_ok;
  logic             bor_evt;
  logic             sw_evt;
  logic             wdog_evt;
  logic [3:0]       aw_addr_reg;
  logic             aw_got_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             w_got_reg;
  logic             wr_en;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [1:0]       rresp_reg;
  logic [31:0]      rdata_reg;
  seq_status_t      seq_status;

  // Three-stage synchroniser per pin; a level counts once stages two and three agree
  assign pin_raw = {osc_clk_in, osc_stable_in, master_reset_pin_n_in,
                    bor_supply_ok_in, por_supply_ok_in};
  for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin
    logic [2:0] sync_reg;
    logic       filt_reg;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
        sync_reg <= {3{PIN_RST_LVL[gi]}};
        filt_reg <= PIN_RST_LVL[gi];
      end else begin
        sync_reg <= {sync_reg[1:0], pin_raw[gi]};
        if (sync_reg[1] == sync_reg[2]) begin
          filt_reg <= sync_reg[2];
        end
      end
    end
    assign pin_filt[gi] = filt_reg;
  end

  assign cold_ok = pin_filt[PIN_POR] & pin_filt[PIN_BOR];
  assign bor_evt = pin_filt[PIN_POR] & ~pin_filt[PIN_BOR];
  assign sw_evt  = sw_reset_instr_in & (state_reg == ST_RUN) & cold_ok;
  assign wdog_evt = wdog_timeout_in & (state_reg == ST_RUN) & cold_ok;

  // Oscillator edge seen through the synchroniser; only slow clocks resolve cleanly
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= pin_filt[PIN_OSC_CLK];
    end
  end
  assign osc_edge = pin_filt[PIN_OSC_CLK] & ~osc_prev_reg;

  // Glitch filter on the reset pin: low for the minimum width before it counts
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      master_reset_pin_n_cnt_reg   <= 8'h00;
      pin_active_reg <= 1'b0;
    end else if (pin_filt[PIN_MASTER_RESET_PIN_N]) begin
      master_reset_pin_n_cnt_reg   <= 8'h00;
      pin_active_reg <= 1'b0;
    end else if (master_reset_pin_n_cnt_reg < 8'(MASTER_RESET_PIN_N_MIN_CYCLES)) begin
      master_reset_pin_n_cnt_reg   <= master_reset_pin_n_cnt_reg + 8'h01;
    end else begin
      pin_active_reg <= 1'b1;
    end
  end
  assign pin_evt = ~pin_filt[PIN_MASTER_RESET_PIN_N] & (master_reset_pin_n_cnt_reg == 8'(MASTER_RESET_PIN_N_MIN_CYCLES))
                   & ~pin_active_reg;

  // Power-up delay: setting 0 is none, setting n is 2^n ms
  assign powerup_timer_cycles = (powerup_delay_select_in == 3'h0) ? '0 :
                       CNT_W'((32'h1 << powerup_delay_select_in) * POWERUP_TIMER_MS_CYCLES);

  // First oscillator wait still owed for a mode after the given stages are done
  function automatic seq_state_t osc_stage(input logic [2:0] mode, input logic up_done,
                                           input logic ost_done);
    osc_stage = ST_RUN;
    if (!up_done && STARTUP_MASK[mode]) begin
      osc_stage = ST_OSC_UP;
    end else if (!ost_done && OST_MASK[mode]) begin
      osc_stage = ST_OST;
    end else if (PLL_MASK[mode]) begin
      osc_stage = ST_PLL;
    end
  endfunction

  // Sequencer next state; a supply drop wins over everything and restarts delays
  always_comb begin
    state_next = state_reg;
    if (!cold_ok) begin
      state_next = ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD:    state_next = por_seen_reg ? ST_POR_EXT : ST_BOR_EXT;
        ST_POR_EXT: if (cnt_reg >= CNT_W'(POR_EXT_CYCLES - 1)) state_next = ST_BOR_EXT;
        ST_BOR_EXT: if (cnt_reg >= CNT_W'(BOR_EXT_CYCLES - 1)) state_next = ST_POWERUP_TIMER;
        ST_POWERUP_TIMER:    if (cnt_reg >= powerup_timer_cycles) begin
          state_next = osc_stage(cfg_osc_select_in, 1'b0, 1'b0);
        end
        ST_OSC_UP:  if (pin_filt[PIN_OSC_OK]) begin
          state_next = osc_stage(current_osc_reg, 1'b1, 1'b0);
        end
        ST_OST:     if (osc_edge && cnt_reg == CNT_W'(OST_EDGES - 1)) begin
          state_next = osc_stage(current_osc_reg, 1'b1, 1'b1);
        end
        ST_PLL:     if (cnt_reg >= CNT_W'(PLL_LOCK_CYCLES - 1)) state_next = ST_RUN;
        ST_RUN:     if (pin_evt || pin_active_reg || sw_evt || wdog_evt) state_next = ST_WARM;
        ST_WARM:    if (!pin_active_reg && !pin_evt) state_next = ST_RUN;
        default:    state_next = ST_HOLD;
      endcase
    end
  end

  // State and stage counter; the counter restarts on every state change
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_HOLD;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= '0;
      end else if ((state_reg != ST_OST || osc_edge) && cnt_reg != '1) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // Cold-reset memory and clock source; warm resets leave the source alone
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      por_seen_reg    <= 1'b1;
      current_osc_reg <= OSC_FRC;
    end else begin
      if (!pin_filt[PIN_POR]) begin
        por_seen_reg <= 1'b1;
      end else if (state_reg == ST_HOLD && cold_ok) begin
        por_seen_reg <= 1'b0;
      end
      if (state_reg == ST_POWERUP_TIMER && state_next != ST_POWERUP_TIMER && cold_ok) begin
        current_osc_reg <= cfg_osc_select_in;
      end
    end
  end

  // Registered outputs: reset held until the power stages end, fetch on clock ready
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      system_reset_reg <= 1'b1;
      clock_ready_reg  <= 1'b0;
      fetch_reg        <= 1'b0;
    end else begin
      system_reset_reg <= (state_next == ST_HOLD) || (state_next == ST_POR_EXT) ||
                          (state_next == ST_BOR_EXT) || (state_next == ST_POWERUP_TIMER) ||
                          (state_next == ST_WARM);
      clock_ready_reg  <= (state_next == ST_RUN) || (state_next == ST_WARM);
      fetch_reg        <= (state_next == ST_RUN) && (state_reg != ST_RUN);
    end
  end

  // Clock monitor waits after clock ready; restarts whenever the clock drops
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      failsafe_clock_monitor_cnt_reg    <= '0;
      failsafe_clock_monitor_active_reg <= 1'b0;
    end else if (!clock_ready_reg || !failsafe_clock_monitor_enable_in) begin
      failsafe_clock_monitor_cnt_reg    <= '0;
      failsafe_clock_monitor_active_reg <= 1'b0;
    end else if (failsafe_clock_monitor_cnt_reg < CNT_W'(FAILSAFE_CLOCK_MONITOR_CYCLES)) begin
      failsafe_clock_monitor_cnt_reg    <= failsafe_clock_monitor_cnt_reg + CNT_W'(1);
    end else begin
      failsafe_clock_monitor_active_reg <= 1'b1;
    end
  end

  assign system_reset_out      = system_reset_reg;
  assign clock_ready_out       = clock_ready_reg;
  assign osc_start_out         = ~system_reset_reg;
  assign fetch_start_out       = fetch_reg;
  assign fetch_addr_out        = RESET_VECTOR;
  assign current_osc_field_out = current_osc_reg;
  assign failsafe_clock_monitor_active_out       = failsafe_clock_monitor_active_reg;
  assign wdog_enabled_out      = wdog_cfg_enable_in | cause_reg[WDSW_BIT];

  // Cause flags: software write first, then hardware clears, then hardware sets win
  assign wr_en = aw_got_reg & w_got_reg & ~bvalid_reg;
  always_comb begin
    cause_next = cause_reg;
    if (wr_en && aw_addr_reg[3:2] == CAUSE_OFFS[3:2]) begin
      if (w_strb_reg[0]) cause_next[7:0]  = w_data_reg[7:0] & CAUSE_IMPL_MASK[7:0];
      if (w_strb_reg[1]) cause_next[15:8] = w_data_reg[15:8] & CAUSE_IMPL_MASK[15:8];
    end
    if (!pin_filt[PIN_POR]) begin
      cause_next = CAUSE_POR_VALUE;
    end else if (bor_evt) begin
      cause_next = cause_next & ~BOR_CLEAR_MASK;
      cause_next[BOR_BIT] = 1'b1;
    end
    if (pin_evt) cause_next[PIN_RESET_FLAG_BIT] = 1'b1;
    if (sw_evt) cause_next[SWR_BIT] = 1'b1;
    if (wdog_evt) cause_next[WDOG_TIMEOUT_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cause_reg <= CAUSE_POR_VALUE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Write channels taken in either order; response once both are held
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_addr_reg <= 4'h0;
      aw_got_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_got_reg  <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_got_reg  <= 1'b1;
      end
      if (wr_en) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (aw_addr_reg[3:2] == CAUSE_OFFS[3:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Read channel; the sequencer word is read-only, unmapped words answer an error
  always_comb begin
    seq_status              = '0;
    seq_status.failsafe_clock_monitor_active  = failsafe_clock_monitor_active_reg;
    seq_status.clock_ready  = clock_ready_reg;
    seq_status.system_reset = system_reset_reg;
    seq_status.current_osc  = current_osc_reg;
    seq_status.state        = state_reg;
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      if (s_axi_araddr[3:2] == CAUSE_OFFS[3:2]) begin
        rdata_reg <= {16'h0000, cause_reg};
      end else if (s_axi_araddr[3:2] == SEQ_OFFS[3:2]) begin
        rdata_reg <= seq_status;
      end else begin
        rdata_reg <= 32'h00000000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Checks
  sequence s_sw_taken;
    sw_evt && !pin_evt && !pin_active_reg && !wdog_timeout_in;
  endsequence
  sequence s_one_cycle_reset;
    system_reset_out && !fetch_start_out ##1 !system_reset_out && fetch_start_out;
  endsequence

  a_por_flag_only: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !pin_filt[PIN_POR] |=> cause_reg == CAUSE_POR_VALUE)
    else $error("power-on did not leave only the power-on flags");
  a_bor_flag_set: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    bor_evt |=> cause_reg[BOR_BIT] && system_reset_out)
    else $error("brown-out flag or reset missing");
  a_write_no_reset: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    wr_en && state_reg == ST_RUN && cold_ok && !pin_evt && !pin_active_reg
    && !sw_reset_instr_in && !wdog_timeout_in |=> !system_reset_out)
    else $error("register write caused a reset");
  a_wdog_forced_on: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    wdog_cfg_enable_in |-> wdog_enabled_out)
    else $error("watchdog not forced on");
  a_cold_osc_latch: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    state_reg == ST_POWERUP_TIMER && state_next != ST_POWERUP_TIMER && cold_ok
    |=> current_osc_field_out == $past(cfg_osc_select_in))
    else $error("cold reset did not take the configured source");
  a_warm_osc_kept: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    state_reg == ST_WARM |=> $stable(current_osc_field_out))
    else $error("warm reset changed the clock source");
  a_ost_edge_count: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    state_reg == ST_OST && state_next != ST_OST && cold_ok
    |-> osc_edge && cnt_reg == CNT_W'(OST_EDGES - 1))
    else $error("start-up timer left early");
  a_pll_lock_wait: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    state_reg == ST_PLL && state_next == ST_RUN |-> cnt_reg >= CNT_W'(PLL_LOCK_CYCLES - 1))
    else $error("PLL lock wait cut short");
  a_fetch_at_vector: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    fetch_start_out |-> fetch_addr_out == RESET_VECTOR && clock_ready_out && !system_reset_out)
    else $error("fetch without ready clock or at wrong address");
  a_failsafe_clock_monitor_after_ready: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(failsafe_clock_monitor_active_out) |-> $past(clock_ready_out, 2) && failsafe_clock_monitor_cnt_reg == CNT_W'(FAILSAFE_CLOCK_MONITOR_CYCLES))
    else $error("clock monitor started off its delay");
  a_por_extension: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    state_reg == ST_POR_EXT && state_next == ST_BOR_EXT |-> cnt_reg == CNT_W'(POR_EXT_CYCLES - 1))
    else $error("power-on extension wrong length");
  a_bor_hold_reset: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !cold_ok |=> system_reset_out && state_reg == ST_HOLD)
    else $error("reset released while supply low");
  a_pin_flag_set: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    pin_evt && pin_filt[PIN_POR] |=> cause_reg[PIN_RESET_FLAG_BIT])
    else $error("pin reset flag not set");
  a_sw_reset_seq: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || !cold_ok)
    s_sw_taken |=> s_one_cycle_reset)
    else $error("reset instruction sequence wrong");
  a_sw_flag_set: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    sw_evt |=> cause_reg[SWR_BIT])
    else $error("software reset flag not set");
  a_wdog_timeout_flag_flag_set: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    wdog_evt |=> cause_reg[WDOG_TIMEOUT_FLAG_BIT] && system_reset_out)
    else $error("watchdog flag or reset missing");

endmodule
`default_nettype wire

/* File: system_reset_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module system_reset_sequencer_tb;
  import rst_seq_pkg::*;
  logic clk_sys_in = 0, resetn_in = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic por_ok = 0, bor_ok = 0, pin_n = 1, sw_rst = 0, wdog_timeout_flag = 0, wdcfg = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, wd;
  logic [1:0] bresp, rresp, rr;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, srst, crdy, ostart, fst, wden, oclk, ostab;
  logic [23:0] faddr;
  logic [3:0] strb = 4'hF;
  logic fsen = 1, fsa;
  logic [2:0] cosc;
  int n_fail = 0, cmp_count = 0, seed = 32'h0c16, model_cause, i;
  always #10 clk_sys_in = ~clk_sys_in;
  // Shortened counts keep the power-on cold start near six thousand cycles
  system_reset_sequencer #(.BOR_EXT_CYCLES(20), .PLL_LOCK_CYCLES(30), .FAILSAFE_CLOCK_MONITOR_CYCLES(20),
    .POWERUP_TIMER_MS_CYCLES(4)) i_system_reset_sequencer (.clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .por_supply_ok_in(por_ok), .bor_supply_ok_in(bor_ok), .master_reset_pin_n_in(pin_n),
    .osc_stable_in(ostab), .osc_clk_in(oclk), .sw_reset_instr_in(sw_rst),
    .wdog_timeout_in(wdog_timeout_flag), .cfg_osc_select_in(3'h2), .powerup_delay_select_in(3'h1),
    .wdog_cfg_enable_in(wdcfg), .failsafe_clock_monitor_enable_in(fsen), .system_reset_out(srst),
    .clock_ready_out(crdy), .osc_start_out(ostart), .fetch_start_out(fst),
    .fetch_addr_out(faddr), .current_osc_field_out(cosc), .wdog_enabled_out(wden),
    .failsafe_clock_monitor_active_out(fsa));
  osc_model i_osc_model (.clk_sys_in(clk_sys_in), .osc_start_in(ostart),
    .osc_clk_out(oclk), .osc_stable_out(ostab));
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ready is sampled mid-cycle so the release lands just after the taking edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int k;
    // Let an edge pass so a back-to-back call never re-drives a just-released strobe
    @(posedge clk_sys_in);
    awaddr <= a; wdata <= d; aw_v <= 1; w_v <= 1; b_r <= 1; tb = 0;
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge clk_sys_in); ta = aw_v & aw_rdy; tw = w_v & w_rdy; tb = b_v; r = bresp;
      @(posedge clk_sys_in); if (ta) aw_v <= 0; if (tw) w_v <= 0; if (tb) b_r <= 0;
    end
    if (!tb) begin n_fail++; conclude(); end
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int k;
    @(posedge clk_sys_in);
    araddr <= a; ar_v <= 1; r_r <= 1; tr = 0;
    for (k = 0; k < 50 && !tr; k++) begin
      @(negedge clk_sys_in); ta = ar_v & ar_rdy; tr = r_v; d = rd; r = rresp;
      @(posedge clk_sys_in); if (ta) ar_v <= 0; if (tr) r_r <= 0;
    end
    if (!tr) begin n_fail++; conclude(); end
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 20000 && crdy !== 1'b1; k++) @(posedge clk_sys_in);
    if (crdy !== 1'b1) begin n_fail++; conclude(); end
  endtask
  task automatic cause_is(input string nm);
    logic [31:0] d;
    axr(CAUSE_OFFS, d, rr); chk(nm, model_cause, d);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1; por_ok <= 1; bor_ok <= 1;
    wait_ready(); @(negedge clk_sys_in);
    chk("fetch_addr", 0, faddr);
    chk("sys_reset", 0, srst);
    model_cause = 3; cause_is("cause_cold");
    chk("osc_source", 2, cosc);
    repeat (30) @(posedge clk_sys_in);
    chk("failsafe_clock_monitor_on", 1, fsa);
    $display("test cold start done");
    for (i = 0; i < 4; i++) begin
      wd = $random(seed); @(posedge clk_sys_in); wdcfg <= wd[16];
      strb <= {2'h3, wd[17], 1'b1};
      axw(CAUSE_OFFS, wd, rr);
      model_cause = (wd[17] ? wd : ((wd & 32'hFF) | (model_cause & 32'hFF00))) & 32'h0000C3FF;
      chk("sys_reset", 0, srst); cause_is("cause_rw");
      chk("wdog_on", wd[16] | model_cause[5], wden);
    end
    $display("test flag access done");
    strb <= 4'hF; axw(CAUSE_OFFS, 0, rr); model_cause = 0;
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_in); if (i == 0) sw_rst <= 1; else wdog_timeout_flag <= 1;
      @(posedge clk_sys_in); sw_rst <= 0; wdog_timeout_flag <= 0;
      @(negedge clk_sys_in); chk("warm_assert", 1, srst);
      @(negedge clk_sys_in); chk("warm_release", 2'b01, {srst, fst});
      chk("clock_kept", 1, crdy);
      model_cause |= (i == 0) ? 32'h40 : 32'h10; cause_is("warm_flag");
    end
    fsen <= 0; repeat (3) @(posedge clk_sys_in);
    chk("failsafe_clock_monitor_off", 0, fsa);
    $display("test warm resets done");
    axr(4'h8, wd, rr); chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    chk("unmapped_rdata", 0, wd);
    axw(4'hC, 1, rr); chk("unmapped_wr", RESP_SLVERR, rr);
    @(posedge clk_sys_in); pin_n <= 0;
    repeat (150) @(posedge clk_sys_in);
    chk("pin_reset", 1, srst);
    pin_n <= 1; repeat (10) @(posedge clk_sys_in);
    chk("pin_release", 0, srst);
    model_cause |= 32'h80; cause_is("pin_flag");
    $display("test pin reset done");
    @(posedge clk_sys_in); bor_ok <= 0;
    repeat (10) @(posedge clk_sys_in);
    chk("bor_hold", 2'b10, {srst, crdy});
    bor_ok <= 1; wait_ready();
    model_cause = (model_cause & ~32'hC27C) | 32'h2; cause_is("bor_flag");
    $display("test brown-out done");
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
